// *** snerf_pkg.sv ***
package snerf_pkg;

    // ****************************************
    // command opcodes
    // ****************************************
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_ERASE = 8'hD8;
    localparam logic [7:0] OP_GETF = 8'h0F;
    localparam logic [7:0] OP_SETF = 8'h1F;
    localparam logic [7:0] OP_SRST = 8'hFF;
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_POR = 8'h99;

    // ****************************************
    // feature addresses
    // ****************************************
    localparam logic [7:0] FA_PROT = 8'hA0;
    localparam logic [7:0] FA_OPT = 8'hB0;
    localparam logic [7:0] FA_STAT = 8'hC0;
    localparam logic [7:0] FA_DRV = 8'hD0;
    localparam logic [7:0] FA_ESTAT = 8'hF0;

    // ****************************************
    // field positions, reset values, write masks
    // ****************************************
    localparam int PROT_WRDIS_BIT = 7;
    localparam int OPT_OTPLOCK_BIT = 7;
    localparam int OPT_ECCEN_BIT = 4;
    localparam int OPT_BPL_BIT = 3;
    localparam int OPT_QE_BIT = 0;
    localparam int DRV_LO_BIT = 5;
    localparam logic [7:0] PROT_RST = 8'h38;
    localparam logic [7:0] OPT_RST = 8'h10;
    localparam logic [7:0] DRV_RST = 8'h00;
    localparam logic [7:0] PROT_WMASK = 8'hBE;
    localparam logic [7:0] OPT_WMASK = 8'hD9;
    localparam logic [7:0] DRV_WMASK = 8'h60;
    localparam logic [7:0] OPT_STICKY = 8'h88;
    localparam logic [2:0] IDX_MAX = 3'h7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int BLOCK_ERASE_TIME_NS = 3000000;
    localparam int BLOCK_ERASE_TIME_CYC = BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS;
    localparam int RESET_RECOVERY_TIME_NS = 50000;
    localparam int RESET_RECOVERY_TIME_CYC = RESET_RECOVERY_TIME_NS / CLK_PERIOD_NS;
    localparam int SRST_NS = 100;
    localparam int SRST_CYC = SRST_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_VERIFY, ST_RESET} snerf_state_t;

endpackage

// *** snerf_core.sv ***
`timescale 1ns/1ps

// Overview of operation
// - erase sequence ignored unless write-enable set the write latch beforehand
// - erase opcode carries 24-bit row address; one block erased per command
// - after address capture, run erase then verify, busy for block_erase_time
// - soft reset aborts program, erase or read and returns to idle
// - accepted power-on reset ends operations and restores all feature defaults
// - every command except get features rejected during reset_recovery_time after power-on reset
// - page or block under work at reset is flagged invalid
// - get and set features take a one-byte feature address
// - written features persist until rewritten or power cycle, survive soft reset
// - protection, option, drive registers writable; status read only; latch via commands
// - protection register frozen while write-disable bit set and protect pin low
// - quad-wide data operations only allowed while quad_enable is one
// - onetime_area_lock is non-volatile; every other feature bit volatile
// - internal correction enable defaults to one at power-up
// - protection_lock freezes protect bits until power cycle; defaults to zero
// - correction status cleared on reset and read start, updated on read end
// - correction status meaningless while internal correction is disabled
// - after power-on reset, correction status holds page zero block zero result
// - busy_flag high while program, read, erase or reset runs
// - erase-fail set on failure or locked block, cleared at erase start or reset
// - write_latch set by enable, cleared by disable, required for erase
// - uncorrectable errors report status 10b with any extension value
module snerf_core import snerf_pkg::*; #(
    parameter int ERASE_CYC = BLOCK_ERASE_TIME_CYC,
    parameter int RECOV_CYC = RESET_RECOVERY_TIME_CYC
) (
    input wire logic clock_in, // core clock
    input wire logic reset_in, // reset, active high; synchronous in the core, asynchronous for the link byte registers
    input wire logic sclk_in, // serial clock
    input wire logic cs_n_in, // chip select, active low
    input wire logic si_in, // serial data in
    output logic so_out, // serial data out
    output logic so_oe_out, // serial out enable
    input wire logic wp_n_in, // write protect pin, active low
    input wire logic array_busy_in, // program or page read running
    input wire logic erase_fail_in, // verify result, valid in verify
    input wire logic erase_locked_in, // addressed block is protected
    input wire logic block_protected_in, // selected block protected
    input wire logic read_start_in, // page read begins
    input wire logic read_done_in, // page read completed validly
    input wire logic [3:0] read_ecc_in, // correction result of read
    input wire logic [3:0] page0_ecc_in, // correction result of page zero
    input wire logic otp_lock_nv_in, // stored one-time lock
    output logic busy_out, // busy flag
    output logic erase_active_out, // array erase pulse phase
    output logic erase_verify_out, // array verify phase
    output logic [23:0] erase_row_out, // row being erased
    output logic abort_out, // abort pulse to array
    output logic invalidate_out, // interrupted contents invalid
    output logic quad_enable_out, // quad operations allowed
    output logic ecc_status_valid_out, // correction status meaningful
    output logic [1:0] drive_strength_out, // output drive setting
    output logic [7:0] block_protect_out // protection register
);

    // ****************************************
    // link side: shifting on the serial clock
    // ****************************************
    logic [2:0] bit_q;
    logic [2:0] idx_q;
    logic [6:0] sh_q;
    logic [7:0] lk_byte_q;
    logic [2:0] lk_idx_q;
    logic lk_tg_q;
    logic [7:0] lk_op_q;
    logic [7:0] lk_fa_q;
    logic so_q;
    logic oe_q;
    logic [39:0] snap_q;
    logic [7:0] rd_byte;

    // frame position is cleared by the frame's own select
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            bit_q <= 3'h0;
            idx_q <= 3'h0;
            sh_q <= 7'h00;
        end else begin
            bit_q <= bit_q + 3'h1;
            sh_q <= {sh_q[5:0], si_in};
            if (bit_q == 3'h7 && idx_q != IDX_MAX) begin
                idx_q <= idx_q + 3'h1;
            end
        end
    end

    // byte handed to the core by toggle; data stays put for a whole byte time
    always_ff @(posedge sclk_in or posedge reset_in) begin
        if (reset_in) begin
            lk_byte_q <= 8'h00;
            lk_idx_q <= 3'h0;
            lk_tg_q <= 1'b0;
            lk_op_q <= 8'h00;
            lk_fa_q <= 8'h00;
        end else if (bit_q == 3'h7) begin
            lk_byte_q <= {sh_q, si_in};
            lk_idx_q <= idx_q;
            lk_tg_q <= ~lk_tg_q;
            if (idx_q == 3'h0) begin
                lk_op_q <= {sh_q, si_in};
            end
            if (idx_q == 3'h1) begin
                lk_fa_q <= {sh_q, si_in};
            end
        end
    end

    // snapshot is frozen by the core for the whole frame, so it is static here
    always_comb begin
        case (lk_fa_q)
            FA_PROT: rd_byte = snap_q[39:32];
            FA_OPT: rd_byte = snap_q[31:24];
            FA_STAT: rd_byte = snap_q[23:16];
            FA_DRV: rd_byte = snap_q[15:8];
            FA_ESTAT: rd_byte = snap_q[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            oe_q <= (lk_op_q == OP_GETF) && (idx_q >= 3'h2);
            so_q <= rd_byte[~bit_q];
        end
    end

    assign so_out = so_q;
    assign so_oe_out = oe_q;

    // ****************************************
    // core side: crossings
    // ****************************************
    logic tg_s1, tg_s2, tg_s3;
    logic cs_s1, cs_s2;
    logic wp_s1, wp_s2;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
            tg_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
        end else begin
            tg_s1 <= lk_tg_q;
            tg_s2 <= tg_s1;
            tg_s3 <= tg_s2;
            cs_s1 <= cs_n_in;
            cs_s2 <= cs_s1;
            wp_s1 <= wp_n_in;
            wp_s2 <= wp_s1;
        end
    end

    // ****************************************
    // command decode
    // ****************************************
    snerf_state_t state_q;
    logic [31:0] tmr_q;
    logic [7:0] op_q, fa_q, prot_q, opt_q, drv_q;
    logic [23:0] row_q, erase_row_q;
    logic cmd_ok_q, wel_q, efail_q, rsten_q, por_pend_q, abort_q, inval_q;
    logic [3:0] ecc_q;
    logic evt, rejecting, busy_op, cmd_evt, srst_hit, por_hit, erase_try;
    logic start_erase, locked_hit, feat_wr, prot_wr_ok, verify_fail, por_end;
    logic [23:0] row_next;
    logic [7:0] opt_new;

    assign evt = tg_s2 ^ tg_s3;
    assign rejecting = state_q == ST_RESET;
    assign busy_op = state_q == ST_ERASE || state_q == ST_VERIFY || array_busy_in;
    assign cmd_evt = evt && lk_idx_q == 3'h0 && !rejecting;
    assign srst_hit = cmd_evt && lk_byte_q == OP_SRST;
    assign por_hit = cmd_evt && lk_byte_q == OP_POR && rsten_q;
    assign row_next = {row_q[15:0], lk_byte_q};
    assign erase_try = evt && lk_idx_q == 3'h3 && op_q == OP_ERASE && cmd_ok_q && !rejecting;
    assign start_erase = erase_try && wel_q && !erase_locked_in;
    assign locked_hit = erase_try && wel_q && erase_locked_in;
    assign feat_wr = evt && lk_idx_q == 3'h2 && op_q == OP_SETF && cmd_ok_q && !rejecting;
    assign prot_wr_ok = !(prot_q[PROT_WRDIS_BIT] && !wp_s2) && !opt_q[OPT_BPL_BIT];
    assign verify_fail = state_q == ST_VERIFY && erase_fail_in;
    assign por_end = state_q == ST_RESET && tmr_q == 32'h0 && por_pend_q;
    // lock and one-time bits only ever go from zero to one by writing
    assign opt_new = (lk_byte_q & OPT_WMASK) | (opt_q & OPT_STICKY);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            op_q <= 8'h00;
            fa_q <= 8'h00;
            row_q <= 24'h000000;
            cmd_ok_q <= 1'b0;
        end else if (evt) begin
            if (lk_idx_q == 3'h0) begin
                op_q <= lk_byte_q;
                cmd_ok_q <= !rejecting && !busy_op;
            end
            if (lk_idx_q == 3'h1) begin
                fa_q <= lk_byte_q;
            end
            if (lk_idx_q >= 3'h1 && lk_idx_q <= 3'h3) begin
                row_q <= row_next;
            end
        end
    end

    // ****************************************
    // feature registers
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            prot_q <= PROT_RST;
            opt_q <= OPT_RST;
            opt_q[OPT_OTPLOCK_BIT] <= otp_lock_nv_in;
            drv_q <= DRV_RST;
        end else if (por_hit) begin
            // soft reset leaves these alone; only the power-on form restores them
            prot_q <= PROT_RST;
            opt_q <= (OPT_RST & ~OPT_STICKY) | (opt_q & 8'h80);
            drv_q <= DRV_RST;
        end else if (feat_wr) begin
            case (fa_q)
                FA_PROT: begin
                    if (prot_wr_ok) begin
                        prot_q <= lk_byte_q & PROT_WMASK;
                    end
                end
                FA_OPT: opt_q <= opt_new;
                FA_DRV: drv_q <= lk_byte_q & DRV_WMASK;
                default: ; // status addresses are read only
            endcase
        end
    end

    a_protect_wp: assert property (@(posedge clock_in) disable iff (reset_in)
        feat_wr && fa_q == FA_PROT && prot_q[PROT_WRDIS_BIT] && !wp_s2 && !por_hit
        |=> $stable(prot_q)) else $error("protection changed while write protected");

    a_lock_freeze: assert property (@(posedge clock_in) disable iff (reset_in)
        opt_q[OPT_BPL_BIT] && !por_hit |=> $stable(prot_q) && opt_q[OPT_BPL_BIT])
        else $error("locked protection bits changed");

    a_por_defaults: assert property (@(posedge clock_in) disable iff (reset_in)
        por_hit |=> prot_q == PROT_RST && drv_q == DRV_RST && opt_q[OPT_ECCEN_BIT]
        && !opt_q[OPT_BPL_BIT] && !wel_q) else $error("power-on defaults not restored");

    a_soft_keeps: assert property (@(posedge clock_in) disable iff (reset_in)
        srst_hit |=> $stable(prot_q) && $stable(opt_q) && $stable(drv_q))
        else $error("soft reset disturbed features");

    // ****************************************
    // write latch, erase fail, reset enable
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (reset_in || por_hit || srst_hit) begin
            wel_q <= 1'b0;
        end else if (cmd_evt && !busy_op && lk_byte_q == OP_WREN) begin
            wel_q <= 1'b1;
        end else if ((cmd_evt && !busy_op && lk_byte_q == OP_WRDI) || start_erase) begin
            wel_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in || por_hit || srst_hit) begin
            efail_q <= 1'b0;
        end else if (verify_fail || locked_hit) begin
            efail_q <= 1'b1;
        end else if (start_erase) begin
            efail_q <= 1'b0;
        end
    end

    // enable must come in the frame before; any other opcode disarms it
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rsten_q <= 1'b0;
        end else if (cmd_evt) begin
            rsten_q <= lk_byte_q == OP_RSTEN;
        end
    end

    a_erase_latch: assert property (@(posedge clock_in) disable iff (reset_in)
        $rose(state_q == ST_ERASE) |-> $past(wel_q) && !wel_q && !efail_q)
        else $error("erase started without write latch");

    a_efail_set: assert property (@(posedge clock_in) disable iff (reset_in)
        (verify_fail || locked_hit) && !srst_hit && !por_hit
        |=> efail_q ##1 (efail_q || $past(evt)))
        else $error("erase fail flag not set");

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_q <= ST_IDLE;
            tmr_q <= 32'h0;
            erase_row_q <= 24'h000000;
            por_pend_q <= 1'b0;
            abort_q <= 1'b0;
            inval_q <= 1'b0;
        end else if (srst_hit || por_hit) begin
            abort_q <= 1'b1;
            inval_q <= busy_op;
            por_pend_q <= por_hit;
            state_q <= ST_RESET;
            tmr_q <= por_hit ? 32'(RECOV_CYC - 1) : 32'(SRST_CYC - 1);
        end else begin
            abort_q <= 1'b0;
            inval_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_erase) begin
                        state_q <= ST_ERASE;
                        tmr_q <= 32'(ERASE_CYC - 2);
                        erase_row_q <= row_next;
                    end
                end
                ST_ERASE: begin
                    if (tmr_q == 32'h0) begin
                        state_q <= ST_VERIFY;
                    end else begin
                        tmr_q <= tmr_q - 32'h1;
                    end
                end
                ST_VERIFY: state_q <= ST_IDLE;
                ST_RESET: begin
                    if (tmr_q == 32'h0) begin
                        state_q <= ST_IDLE;
                        por_pend_q <= 1'b0;
                    end else begin
                        tmr_q <= tmr_q - 32'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    a_erase_row: assert property (@(posedge clock_in) disable iff (reset_in)
        start_erase && !srst_hit |=> erase_row_q == $past(row_next) && state_q == ST_ERASE)
        else $error("erase row not captured");

    a_erase_end: assert property (@(posedge clock_in) disable iff (reset_in)
        state_q == ST_ERASE && tmr_q == 32'h0 && !srst_hit && !por_hit
        |=> state_q == ST_VERIFY ##1 (state_q == ST_IDLE || $past(evt)))
        else $error("erase did not verify then finish");

    a_reset_abort: assert property (@(posedge clock_in) disable iff (reset_in)
        srst_hit |=> abort_q && state_q == ST_RESET ##1 !abort_q)
        else $error("soft reset did not abort");

    a_recovery_reject: assert property (@(posedge clock_in) disable iff (reset_in)
        state_q == ST_RESET |-> !start_erase && !feat_wr && !srst_hit && !por_hit)
        else $error("command accepted during reset recovery");

    a_busy_flag: assert property (@(posedge clock_in) disable iff (reset_in)
        busy_out == (state_q != ST_IDLE || array_busy_in))
        else $error("busy flag wrong");

    // ****************************************
    // correction status
    // ****************************************
    always_ff @(posedge clock_in) begin
        if (reset_in || srst_hit || por_hit) begin
            ecc_q <= 4'h0;
        end else if (por_end) begin
            ecc_q <= page0_ecc_in;
        end else if (read_done_in) begin
            ecc_q <= read_ecc_in;
        end else if (read_start_in) begin
            ecc_q <= 4'h0;
        end
    end

    a_ecc_clear: assert property (@(posedge clock_in) disable iff (reset_in)
        read_start_in && !read_done_in && !por_end |=> ecc_q == 4'h0)
        else $error("correction status not cleared at read start");

    a_ecc_page0: assert property (@(posedge clock_in) disable iff (reset_in)
        por_end && !srst_hit && !por_hit |=> ecc_q == $past(page0_ecc_in))
        else $error("page zero status not loaded");

    // ****************************************
    // snapshot for reads and outputs
    // ****************************************
    // updated only between frames so the link never samples a moving word;
    // a busy poll therefore sees the state from before its frame began
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            snap_q <= 40'h0;
        end else if (cs_s2) begin
            snap_q <= {prot_q, opt_q,
                2'b00, ecc_q[3:2], 1'b0, efail_q, wel_q, busy_out,
                drv_q,
                2'b00, ecc_q[1:0], block_protected_in, 3'b000};
        end
    end

    assign busy_out = state_q != ST_IDLE || array_busy_in;
    assign erase_active_out = state_q == ST_ERASE;
    assign erase_verify_out = state_q == ST_VERIFY;
    assign erase_row_out = erase_row_q;
    assign abort_out = abort_q;
    assign invalidate_out = inval_q;
    assign quad_enable_out = opt_q[OPT_QE_BIT];
    assign ecc_status_valid_out = opt_q[OPT_ECCEN_BIT];
    assign drive_strength_out = drv_q[DRV_LO_BIT+1:DRV_LO_BIT];
    assign block_protect_out = prot_q;

endmodule

// *** snerf_host.sv ***
`timescale 1ns/1ps
module snerf_host (
    output logic sclk_out, // serial clock, low between frames
    output logic cs_n_out, // chip select, active low
    output logic si_out, // serial data to device
    input wire logic so_in // serial data from device
);
    // ****************************************
    // one frame, msb first, 32 ns bit time
    // ****************************************
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // rx keeps the last eight bits sampled on so_in
    task automatic frame(input logic [31:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        cs_n_out = 1'b0;
        for (int i = 0; i < n * 8; i++) begin
            si_out = tx[31 - i];
            #16 sclk_out = 1'b1;
            rx = {rx[6:0], so_in};
            #16 sclk_out = 1'b0;
        end
        #16 cs_n_out = 1'b1;
        si_out = ~si_out;
        #200;
    endtask
endmodule

// *** test_spi_nand_erase_reset_features.sv ***
`timescale 1ns/1ps
module test_spi_nand_erase_reset_features;
    import snerf_pkg::*;
    localparam int ERASE_N = 2000;
    localparam int RECOV_N = 400;
    logic clock_in, reset_in, sclk, cs_n, si, so, wp_n, efail, elock, bprot, rs, rd;
    logic busy, abort, inval, qe, eccv, oe, act, ver;
    logic [3:0] recc, p0;
    logic [1:0] drv;
    logic [7:0] bp, rx, d, a, pv;
    logic [23:0] row, row_q;
    logic [7:0] fa [3] = '{FA_PROT, FA_OPT, FA_DRV};
    int errors, n_tests, cyc, n_busy, n_abort, n_inval, n_oe, n_act, n_ver;
    snerf_host u_snerf_host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so));
    snerf_core #(.ERASE_CYC(ERASE_N), .RECOV_CYC(RECOV_N)) u_snerf_core (
        .clock_in(clock_in), .reset_in(reset_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .si_in(si), .so_out(so), .so_oe_out(oe), .wp_n_in(wp_n), .array_busy_in(1'b0),
        .erase_fail_in(efail), .erase_locked_in(elock), .block_protected_in(bprot),
        .read_start_in(rs), .read_done_in(rd), .read_ecc_in(recc), .page0_ecc_in(p0),
        .otp_lock_nv_in(1'b0), .busy_out(busy), .erase_active_out(act),
        .erase_verify_out(ver), .erase_row_out(row_q), .abort_out(abort),
        .invalidate_out(inval), .quad_enable_out(qe), .ecc_status_valid_out(eccv),
        .drive_strength_out(drv), .block_protect_out(bp));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] wr_mask(input logic [7:0] fa_addr);
        return fa_addr == FA_PROT ? PROT_WMASK : fa_addr == FA_OPT ? OPT_WMASK : DRV_WMASK;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic [7:0] c, input logic [23:0] arg = 24'h0, input int n = 1);
        u_snerf_host.frame({c, arg}, n, rx);
    endtask
    task automatic setf(input logic [7:0] fa_addr, input logic [7:0] v);
        op(OP_SETF, {fa_addr, v, 8'h00}, 3);
    endtask
    // reserved and unwatched bits masked off
    task automatic getc(input logic [7:0] fa_addr, input logic [7:0] m, input logic [7:0] e);
        op(OP_GETF, {fa_addr, 16'h0000}, 3);
        check(rx & m, e);
    endtask
    task automatic rd_evt(input logic s, input logic dn);
        @(negedge clock_in);
        {rs, rd} = {s, dn};
        @(negedge clock_in);
        {rs, rd} = 2'b00;
    endtask
    task automatic idle;
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clock_in);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    // cut a hang short after far more than the sequence needs
    always @(posedge clock_in) begin
        cyc++;
        if (busy === 1'b1) n_busy++;
        if (abort === 1'b1) n_abort++;
        if (inval === 1'b1) n_inval++;
        if (oe === 1'b1) n_oe++;
        if (act === 1'b1) n_act++;
        if (ver === 1'b1) n_ver++;
        if (cyc == 60000) begin
            errors++;
            tally_and_finish;
        end
    end
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        void'($urandom(26283));
        {reset_in, wp_n, efail, elock, bprot, rs, rd} = 7'b1100100;
        recc = 4'h0;
        p0 = 4'($urandom);
        repeat (16) @(negedge clock_in);
        reset_in = 1'b0;
        @(negedge clock_in);
        getc(FA_PROT, 8'hFF, PROT_RST);
        getc(FA_OPT, 8'hFF, OPT_RST);
        getc(FA_DRV, 8'hFF, DRV_RST);
        getc(FA_ESTAT, 8'h08, 8'h08);
        // each read drives so for 8.5 bit times, 68 core cycles
        check(n_oe, 4 * 68);
        for (int k = 0; k < 12; k++) begin
            a = fa[k % 3];
            d = 8'($urandom) & wr_mask(a) & ~OPT_STICKY;
            setf(a, d);
            getc(a, 8'hFF, d);
            if (a == FA_PROT) pv = d;
        end
        check(drv, d[6:5]);
        check(bp, pv);
        d = 8'($urandom) & OPT_WMASK & ~OPT_STICKY;
        setf(FA_OPT, d);
        check({qe, eccv}, {d[OPT_QE_BIT], d[OPT_ECCEN_BIT]});
        setf(FA_STAT, 8'hFF);
        getc(FA_STAT, 8'h07, 8'h00);
        recc = 4'($urandom);
        rd_evt(1'b0, 1'b1);
        getc(FA_ESTAT, 8'h30, {2'b00, recc[1:0], 4'h0});
        getc(FA_STAT, 8'h30, {2'b00, recc[3:2], 4'h0});
        rd_evt(1'b1, 1'b0);
        getc(FA_ESTAT, 8'h30, 8'h00);
        row = 24'($urandom);
        op(OP_ERASE, row, 4);
        getc(FA_STAT, 8'h07, 8'h00);
        op(OP_WREN);
        getc(FA_STAT, 8'h07, 8'h02);
        op(OP_WRDI);
        getc(FA_STAT, 8'h07, 8'h00);
        op(OP_WREN);
        efail = 1'b1;
        {n_busy, n_act, n_ver} = 0;
        op(OP_ERASE, row, 4);
        getc(FA_STAT, 8'h07, 8'h01);
        check(row_q, row);
        idle;
        check(32'(n_busy >= ERASE_N - 1 && n_busy <= ERASE_N + 1), 1);
        check({n_act[15:0], n_ver[15:0]}, {16'(ERASE_N - 1), 16'h0001});
        getc(FA_STAT, 8'h07, 8'h04);
        // clear the fail flag first so the locked attempt must set it afresh
        op(OP_SRST);
        idle;
        getc(FA_STAT, 8'h07, 8'h00);
        op(OP_WREN);
        elock = 1'b1;
        n_busy = 0;
        op(OP_ERASE, row, 4);
        check(n_busy, 0);
        getc(FA_STAT, 8'h05, 8'h04);
        {elock, efail} = 2'b00;
        pv = 8'($urandom) & PROT_WMASK & 8'h7F;
        setf(FA_PROT, pv);
        op(OP_WREN);
        n_busy = 0;
        op(OP_ERASE, row ^ 24'h000001, 4);
        getc(FA_STAT, 8'h05, 8'h01);
        {n_abort, n_inval} = 0;
        op(OP_SRST);
        idle;
        check({n_abort[7:0], n_inval[7:0]}, 16'h0101);
        check(32'(n_busy < ERASE_N), 1);
        getc(FA_PROT, 8'hFF, pv);
        wp_n = 1'b0;
        setf(FA_PROT, 8'h80);
        setf(FA_PROT, 8'h3C);
        getc(FA_PROT, 8'hFF, 8'h80);
        wp_n = 1'b1;
        setf(FA_PROT, 8'h00);
        setf(FA_OPT, 8'h08);
        setf(FA_PROT, 8'h3C);
        getc(FA_PROT, 8'hFF, 8'h00);
        n_busy = 0;
        op(OP_RSTEN);
        op(OP_POR);
        op(OP_WREN);
        idle;
        check(32'(n_busy >= RECOV_N - 1 && n_busy <= RECOV_N + 1), 1);
        getc(FA_STAT, 8'h07, 8'h00);
        getc(FA_PROT, 8'hFF, PROT_RST);
        getc(FA_OPT, 8'hFF, OPT_RST);
        getc(FA_ESTAT, 8'h30, {2'b00, p0[1:0], 4'h0});
        tally_and_finish;
    end
endmodule
